// ---- verilog/mute_cmd_regs.svh ----
`ifndef MUTE_CMD_REGS_SVH
`define MUTE_CMD_REGS_SVH
`define STR_MAX_LEN 32
`define STR_LEN_W 6
`define NUM_XPT 2
`define NUM_WBUS_XPT 8
`define NUM_INPUTS 1
`define XPT_RESET 2'h0
`define WXPT_RESET 8'h00
`define IMUTE_RESET 1'h0
`define MODEM_EN_RESET 1'h0
`endif

// ---- verilog/mute_cmd_pkg.sv ----
`default_nettype none
package mute_cmd_pkg;
  typedef enum logic [2:0] {
    CMD_MODEM_STR,
    CMD_XPT_MUTE,
    CMD_XPT_ALL,
    CMD_WBUS_MUTE,
    CMD_IN_MUTE,
    CMD_IN_ALL
  } cmd_t;
  typedef enum logic [2:0] {
    VAL_ZERO,
    VAL_ONE,
    VAL_TOGGLE,
    VAL_QUERY,
    VAL_DIGITS,
    VAL_BAD
  } val_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_NV_WAIT,
    ST_REPLY
  } state_t;
endpackage
`default_nettype wire

// ---- verilog/mute_and_modem_string_commands.sv ----
// Operation
// - Modem string holds at most 32 characters.
// - Modem string change writes global storage.
// - Acknowledge string change after storage write.
// - New string stored, echoed with text.
// - String query reports the stored text.
// - Power-up sending follows separate enable.
// - Send string at power-up only if enabled.
// - Crosspoint value one mutes, echoed back.
// - Crosspoint value two toggles, reports result.
// - Crosspoint query reports state unchanged.
// - Bus submatrix crosspoints use same semantics.
// - Asterisk digit string sets crosspoints in order.
// - Asterisk with zero unmutes all crosspoints.
// - Asterisk with two toggles each crosspoint.
// - Asterisk query reports all crosspoints in order.
// - Input mute value one mutes, zero unmutes.
// - Input mute value two toggles state.
// - Input mute query reports state unchanged.
// - Asterisk input applies to every input.
// - Asterisk input query reports each input.
`timescale 1ns/1ps
`include "mute_cmd_regs.svh"
`default_nettype none
module mute_and_modem_string_commands
  import mute_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Parsed command from the framing logic
  input wire logic cmd_valid,
  input wire cmd_t cmd_kind,
  input wire val_t cmd_value,
  input wire logic [1:0] cmd_digits,
  input wire logic cmd_xpt_sel,
  input wire logic [2:0] cmd_wbus_sel,
  input wire logic [7:0] cmd_char,
  input wire logic cmd_char_last,
  // Modem string read port
  input wire logic [4:0] str_rd_index,
  output logic [7:0] str_rd_char,
  output logic [5:0] str_len,
  // Non-volatile storage handshake
  output logic nv_write_req,
  input wire logic nv_write_done,
  // Power-up send and its enable setting
  input wire logic modem_init_enable_cmd,
  input wire logic power_up,
  output logic modem_send_req,
  // Status reply
  output logic reply_valid,
  output var cmd_t reply_kind,
  output logic [1:0] reply_digits,
  output logic cmd_ready,
  // Mute states toward the audio path
  output logic [1:0] xpt_mute,
  output logic [7:0] wbus_mute,
  output logic input_mute
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  state_t state_q;
  logic [7:0] str_q [0:`STR_MAX_LEN-1];
  logic [5:0] len_q;
  logic [5:0] wlen_q;
  logic [1:0] xpt_q;
  logic [7:0] wbus_q;
  logic imute_q;
  logic [1:0] rep_q;
  cmd_t rkind_q;
  logic enable_q;

  function automatic logic apply_val(input val_t v, input logic cur,
                                     input logic dig);
    case (v)
      VAL_ZERO: apply_val = 1'h0;
      VAL_ONE: apply_val = 1'h1;
      VAL_TOGGLE: apply_val = ~cur;
      VAL_DIGITS: apply_val = dig;
      default: apply_val = cur;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire logic take = cmd_valid && (state_q == ST_IDLE);
  wire logic good_val = (cmd_value != VAL_BAD);
  wire logic is_str = take && (cmd_kind == CMD_MODEM_STR);
  wire logic str_wr = is_str && (cmd_value != VAL_QUERY) && good_val;
  // Characters past the limit are dropped, not wrapped.
  wire logic str_room = (wlen_q < 6'(`STR_MAX_LEN));
  wire logic do_mute = take && good_val && (cmd_kind != CMD_MODEM_STR);
  wire logic xpt_new = apply_val(cmd_value, xpt_q[cmd_xpt_sel], 1'h0);
  wire logic w_new = apply_val(cmd_value, wbus_q[cmd_wbus_sel], 1'h0);
  wire logic i_new = apply_val(cmd_value, imute_q, 1'h0);
  wire logic [1:0] xall_new;
  // Digit strings map first digit to the phone output, bit 0.
  genvar g;
  generate
    for (g = 0; g < `NUM_XPT; g = g + 1) begin : g_xall
      assign xall_new[g] = apply_val(cmd_value, xpt_q[g],
                                     cmd_digits[g]);
    end
  endgenerate

  assign cmd_ready = (state_q == ST_IDLE);
  assign reply_valid = (state_q == ST_REPLY);
  assign reply_kind = rkind_q;
  assign reply_digits = rep_q;
  assign nv_write_req = (state_q == ST_NV_WAIT);
  assign str_rd_char = str_q[str_rd_index];
  assign str_len = len_q;
  assign xpt_mute = xpt_q;
  assign wbus_mute = wbus_q;
  assign input_mute = imute_q;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // A string write spans several command beats, one character each;
  // the last beat starts the storage write and the reply waits on it.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:
          if (str_wr && cmd_char_last) begin
            state_q <= ST_NV_WAIT;
          end else if (take && !(str_wr && !cmd_char_last)) begin
            state_q <= ST_REPLY;
          end
        ST_NV_WAIT:
          if (nv_write_done) begin
            state_q <= ST_REPLY;
          end
        ST_REPLY: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wlen_q <= 6'h00;
      len_q <= 6'h00;
    end else if (str_wr) begin
      wlen_q <= cmd_char_last ? 6'h00 : wlen_q + {5'h00, str_room};
      if (cmd_char_last) begin
        len_q <= wlen_q + {5'h00, str_room};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (str_wr && str_room) begin
      str_q[wlen_q[4:0]] <= cmd_char;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      xpt_q <= `XPT_RESET;
      wbus_q <= `WXPT_RESET;
      imute_q <= `IMUTE_RESET;
    end else if (do_mute) begin
      case (cmd_kind)
        CMD_XPT_MUTE: xpt_q[cmd_xpt_sel] <= xpt_new;
        CMD_XPT_ALL: xpt_q <= xall_new;
        CMD_WBUS_MUTE: wbus_q[cmd_wbus_sel] <= w_new;
        CMD_IN_MUTE: imute_q <= i_new;
        CMD_IN_ALL: imute_q <= i_new;
        default: imute_q <= imute_q;
      endcase
    end
  end

  // Reply digits are the state after the command; queries see it
  // unchanged because the value decode leaves it alone.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rep_q <= 2'h0;
      rkind_q <= CMD_MODEM_STR;
    end else if (take) begin
      rkind_q <= cmd_kind;
      case (cmd_kind)
        CMD_XPT_MUTE: rep_q <= {1'h0, good_val ? xpt_new
                                : xpt_q[cmd_xpt_sel]};
        CMD_XPT_ALL: rep_q <= good_val ? xall_new : xpt_q;
        CMD_WBUS_MUTE: rep_q <= {1'h0, good_val ? w_new
                                 : wbus_q[cmd_wbus_sel]};
        CMD_IN_MUTE: rep_q <= {1'h0, good_val ? i_new : imute_q};
        CMD_IN_ALL: rep_q <= {1'h0, good_val ? i_new : imute_q};
        default: rep_q <= 2'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Power-up send
  // ---------------------------------------------------------------
  // The enable is caught on the clock, never under the reset itself.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= `MODEM_EN_RESET;
      modem_send_req <= 1'h0;
    end else begin
      enable_q <= modem_init_enable_cmd;
      modem_send_req <= power_up && enable_q;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  nv_before_ack_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q == ST_NV_WAIT && !nv_write_done) |=> !reply_valid)
    else $error("reply before storage write done");
  nv_ack_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state_q == ST_NV_WAIT && nv_write_done) |=> reply_valid)
    else $error("no reply after storage write");
  nv_req_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (str_wr && cmd_char_last) |=> nv_write_req)
    else $error("string change without storage write");
  len_max_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    len_q <= 6'(`STR_MAX_LEN))
    else $error("string too long");
  str_query_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (is_str && cmd_value == VAL_QUERY) |=> reply_valid && $stable(len_q))
    else $error("string query not answered");
  send_gate_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    modem_send_req |-> $past(modem_init_enable_cmd, 2))
    else $error("modem string sent while disabled");
  send_on_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    ($past(power_up) && $past(modem_init_enable_cmd, 2) && $past(reset_n)
     && $past(reset_n, 2)) |-> modem_send_req)
    else $error("modem string not sent while enabled");

  // ---------------------------------------------------------------
  // Mute checks
  // ---------------------------------------------------------------
  // Each check but reply_pulse_a looks one cycle after the take, where the new state and
  // the reply digits stand together, so a lost write shows at once.
  reply_pulse_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    reply_valid |=> !reply_valid)
    else $error("reply longer than one cycle");
  mute_echo_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (take && cmd_kind != CMD_MODEM_STR)
    |=> reply_valid && reply_kind == $past(cmd_kind))
    else $error("mute command not echoed");
  xpt_one_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (do_mute && cmd_kind == CMD_XPT_MUTE && cmd_value == VAL_ONE)
    |=> xpt_q[$past(cmd_xpt_sel)] && reply_digits == 2'h1)
    else $error("crosspoint mute not applied");
  xpt_toggle_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (do_mute && cmd_kind == CMD_XPT_MUTE && cmd_value == VAL_TOGGLE)
    |=> xpt_q[$past(cmd_xpt_sel)] != $past(xpt_q[cmd_xpt_sel]))
    else $error("crosspoint toggle failed");
  xpt_query_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (take && cmd_value == VAL_QUERY) |=> $stable(xpt_q)
    && $stable(imute_q) && $stable(wbus_q))
    else $error("query changed state");
  wbus_toggle_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (do_mute && cmd_kind == CMD_WBUS_MUTE && cmd_value == VAL_TOGGLE)
    |=> wbus_q[$past(cmd_wbus_sel)] != $past(wbus_q[cmd_wbus_sel]))
    else $error("bus crosspoint toggle failed");
  xall_digits_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (do_mute && cmd_kind == CMD_XPT_ALL && cmd_value == VAL_DIGITS)
    |=> xpt_q == $past(cmd_digits))
    else $error("digit string not applied");
  xall_zero_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (do_mute && cmd_kind == CMD_XPT_ALL && cmd_value == VAL_ZERO)
    |=> xpt_q == 2'h0 && reply_digits == 2'h0)
    else $error("crosspoints not all unmuted");
  xall_toggle_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (do_mute && cmd_kind == CMD_XPT_ALL && cmd_value == VAL_TOGGLE)
    |=> xpt_q == ~$past(xpt_q))
    else $error("crosspoints not all toggled");
  xall_query_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (take && cmd_kind == CMD_XPT_ALL && cmd_value == VAL_QUERY)
    |=> reply_digits == $past(xpt_q))
    else $error("crosspoint query reported wrong digits");
  in_mute_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (do_mute && cmd_kind == CMD_IN_MUTE && cmd_value == VAL_ONE)
    |=> imute_q && reply_digits == 2'h1)
    else $error("input mute not applied");
  in_toggle_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (do_mute && cmd_kind == CMD_IN_MUTE && cmd_value == VAL_TOGGLE)
    |=> imute_q != $past(imute_q))
    else $error("input mute toggle failed");
  in_query_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (take && (cmd_kind == CMD_IN_MUTE || cmd_kind == CMD_IN_ALL)
     && cmd_value == VAL_QUERY) |=> reply_digits == {1'h0, $past(imute_q)})
    else $error("input query reported wrong digit");
  in_all_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (do_mute && cmd_kind == CMD_IN_ALL
     && (cmd_value == VAL_ZERO || cmd_value == VAL_ONE))
    |=> imute_q == ($past(cmd_value) == VAL_ONE))
    else $error("all-input mute not applied");
  bad_val_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (take && cmd_value == VAL_BAD) |=> $stable(xpt_q) && $stable(wbus_q)
    && $stable(len_q) && $stable(imute_q))
    else $error("bad value changed state");

endmodule // mute_and_modem_string_commands
`default_nettype wire

// ---- verification/nv_store_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nv_store_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Storage write handshake
  input wire logic req,
  output logic done,
  input wire logic [7:0] lag
);
  // ----
  // Storage write timing
  // ----
  // A long lag stands for a slow storage part, so the ack must wait.
  logic [7:0] cnt_q;
  logic hit;
  assign hit = req && !done && cnt_q == lag;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= hit;
      cnt_q <= (req && !done && !hit) ? cnt_q + 8'h01 : 8'h00;
    end
  end
endmodule // nv_store_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb import mute_cmd_pkg::*; ;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_t cmd_kind = CMD_XPT_MUTE;
  val_t cmd_value = VAL_ZERO;
  logic [1:0] cmd_digits = 2'h0;
  logic cmd_xpt_sel = 1'b0;
  logic [2:0] cmd_wbus_sel = 3'h0;
  logic [7:0] cmd_char = 8'h00;
  logic cmd_char_last = 1'b0;
  logic [4:0] str_rd_index = 5'h00;
  logic modem_init_enable_cmd = 1'b0;
  logic power_up = 1'b0;
  logic [7:0] str_rd_char, wbus_mute, wm = 8'h00, lag = 8'h03;
  logic [5:0] str_len;
  logic [1:0] reply_digits, xpt_mute, xm = 2'h0;
  logic nv_write_req, nv_write_done, modem_send_req, reply_valid;
  logic cmd_ready, input_mute, im = 1'b0, nv_seen = 1'b0;
  cmd_t reply_kind, rk;
  val_t rv;
  logic [7:0] txt [0:33];
  logic [6:0] exp_q [$];
  logic [6:0] e;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  mute_and_modem_string_commands u_dut (.clock, .reset_n, .cmd_valid,
    .cmd_kind, .cmd_value, .cmd_digits, .cmd_xpt_sel, .cmd_wbus_sel,
    .cmd_char, .cmd_char_last, .str_rd_index, .str_rd_char, .str_len,
    .nv_write_req, .nv_write_done, .modem_init_enable_cmd, .power_up,
    .modem_send_req, .reply_valid, .reply_kind, .reply_digits,
    .cmd_ready, .xpt_mute, .wbus_mute, .input_mute);
  nv_store_model u_nv (.clock, .reset_n, .req(nv_write_req),
    .done(nv_write_done), .lag);
  always #25 clock = ~clock;
  task automatic check(string nm, logic [7:0] x, logic [7:0] s);
    cmp_count++;
    if (x !== s) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----
  // Reply watcher
  // ----
  // Sampled on the falling edge so the reply pulse has settled.
  always @(negedge clock) begin
    if (reply_valid === 1'b1) begin
      if (exp_q.size() == 0) check("spare reply", 8'h00, 8'h01);
      else begin
        e = exp_q.pop_front();
        check("reply kind", e[4:2], reply_kind);
        if (!e[5]) check("reply digits", e[1:0], reply_digits);
        if (e[6]) check("storage before ack", 8'h01, nv_seen);
      end
    end
  end
  always @(posedge clock) begin
    if (nv_write_done === 1'b1) nv_seen <= 1'b1;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  function automatic logic upd(logic o, val_t v);
    return v == VAL_ZERO ? 1'b0 : v == VAL_ONE ? 1'b1 : v == VAL_TOGGLE ? !o : o;
  endfunction
  task automatic wait_idle(logic need_nv);
    for (int t = 0; t < 60 && (cmd_ready !== 1'b1 || !nv_seen && need_nv);
         t++) begin
      @(posedge clock);
      #2;
    end
  endtask
  task automatic do_cmd(cmd_t k, val_t v, logic [1:0] d, logic s,
                        logic [2:0] w);
    logic [1:0] r;
    r = 2'h0;
    case (k)
      CMD_MODEM_STR: r = 2'h0;
      CMD_XPT_MUTE: begin
        xm[s] = upd(xm[s], v);
        r = {1'b0, xm[s]};
      end
      CMD_XPT_ALL: begin
        xm = v == VAL_DIGITS ? d : v == VAL_TOGGLE ? ~xm :
             v == VAL_ZERO ? 2'h0 : v == VAL_ONE ? 2'h3 : xm;
        r = xm;
      end
      CMD_WBUS_MUTE: begin
        wm[w] = upd(wm[w], v);
        r = {1'b0, wm[w]};
      end
      default: begin
        im = upd(im, v);
        r = {1'b0, im};
      end
    endcase
    exp_q.push_back({1'b0, k == CMD_MODEM_STR, k, r});
    {cmd_kind, cmd_value, cmd_digits} = {k, v, d};
    {cmd_xpt_sel, cmd_wbus_sel, cmd_valid} = {s, w, 1'b1};
    @(posedge clock);
    #2;
    cmd_valid = 1'b0;
    wait_idle(1'b0);
    check("crosspoints", xm, xpt_mute);
    check("bus crosspoints", wm, wbus_mute);
    check("input mute", im, input_mute);
  endtask
  task automatic str_write(int n);
    nv_seen = 1'b0;
    exp_q.push_back({2'b11, CMD_MODEM_STR, 2'b00});
    {cmd_kind, cmd_value, cmd_valid} = {CMD_MODEM_STR, VAL_ONE, 1'b1};
    for (int i = 0; i < n; i++) begin
      txt[i] = 8'h20 + 8'($urandom_range(0, 94));
      cmd_char = txt[i];
      cmd_char_last = (i == n - 1);
      @(posedge clock);
      #2;
    end
    {cmd_valid, cmd_char_last} = 2'b00;
    check("storage request", 8'h01, nv_write_req);
    check("ready in wait", 8'h00, cmd_ready);
    wait_idle(1'b1);
    check("length", 8'(n > 32 ? 32 : n), str_len);
    for (int i = 0; i < 32 && i < n; i++) begin
      str_rd_index = 5'(i);
      @(posedge clock);
      #2 check("text", txt[i], str_rd_char);
    end
  endtask
  task automatic pwr(logic en);
    modem_init_enable_cmd = en;
    @(posedge clock);
    #2 power_up = 1'b1;
    @(posedge clock);
    #2 power_up = 1'b0;
    check("power-up send", en, modem_send_req);
  endtask
  initial begin
    void'($urandom(32'h83BBE50B));
    repeat (16) @(posedge clock);
    #2 reset_n = 1'b1;
    @(posedge clock);
    #2;
    do_cmd(CMD_XPT_MUTE, VAL_ONE, 2'h0, 1'b1, 3'h0);
    do_cmd(CMD_XPT_MUTE, VAL_TOGGLE, 2'h0, 1'b1, 3'h0);
    do_cmd(CMD_XPT_MUTE, VAL_QUERY, 2'h0, 1'b1, 3'h0);
    do_cmd(CMD_XPT_ALL, VAL_DIGITS, 2'h1, 1'b0, 3'h0);
    do_cmd(CMD_XPT_ALL, VAL_TOGGLE, 2'h0, 1'b0, 3'h0);
    do_cmd(CMD_XPT_ALL, VAL_ZERO, 2'h3, 1'b0, 3'h0);
    do_cmd(CMD_XPT_ALL, VAL_QUERY, 2'h3, 1'b0, 3'h0);
    do_cmd(CMD_WBUS_MUTE, VAL_ONE, 2'h0, 1'b0, 3'h7);
    do_cmd(CMD_IN_MUTE, VAL_ONE, 2'h0, 1'b0, 3'h0);
    do_cmd(CMD_IN_MUTE, VAL_TOGGLE, 2'h0, 1'b0, 3'h0);
    do_cmd(CMD_IN_MUTE, VAL_QUERY, 2'h0, 1'b0, 3'h0);
    do_cmd(CMD_IN_ALL, VAL_ONE, 2'h0, 1'b0, 3'h0);
    do_cmd(CMD_IN_ALL, VAL_QUERY, 2'h0, 1'b0, 3'h0);
    do_cmd(CMD_XPT_ALL, VAL_BAD, 2'h3, 1'b0, 3'h0);
    $display("test directed mutes done");
    for (int i = 0; i < 150; i++) begin
      rk = cmd_t'($urandom_range(1, 5));
      rv = val_t'($urandom_range(0, 5));
      if (rv == VAL_DIGITS && rk != CMD_XPT_ALL) rv = VAL_BAD;
      do_cmd(rk, rv, 2'($urandom), 1'($urandom), 3'($urandom));
    end
    $display("test random mutes done");
    str_write(13);
    lag = 8'h14;
    str_write(34);
    do_cmd(CMD_MODEM_STR, VAL_QUERY, 2'h0, 1'b0, 3'h0);
    check("length kept", 8'h20, str_len);
    $display("test modem string done");
    pwr(1'b1);
    pwr(1'b0);
    check("replies owed", 8'h00, 8'(exp_q.size()));
    $display("test power-up send done");
    test_done();
  end
endmodule // tb
`default_nettype wire
